//--- verilog/pdt_pkg.sv
// shared constants for the pd message transmit path, both ends
package pdt_pkg;
   // device register map, byte addresses on the link
   localparam logic [7:0] ADDR_ALERT_LO = 8'h10;
   localparam logic [7:0] ADDR_ALERT_HI = 8'h11;
   localparam logic [7:0] ADDR_MASK_LO = 8'h12;
   localparam logic [7:0] ADDR_MASK_HI = 8'h13;
   localparam logic [7:0] ADDR_TX_CMD = 8'h50;
   localparam logic [7:0] ADDR_TX_BUF = 8'h51;
   localparam logic [7:0] ADDR_TX_BUF_END = 8'h6f;
   localparam int TX_BUF_LEN = 31;
   localparam logic [7:0] MAX_DATA_BYTES = 8'h1e;
   localparam logic [7:0] CMD_SEND = 8'h30;
   // alert status fields
   localparam logic [7:0] ST_SEND_OK = 8'h40;
   localparam logic [7:0] ST_FAULT = 8'h02;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // line timing: one bmc unit interval, split in two halves
   localparam int CLK_NS = 100;
   localparam int UI_NS = 3330;
   localparam int HALF_UI_CYC = UI_NS / (2 * CLK_NS);
   localparam int PREAMBLE_BITS = 64;
   localparam int CRC_BITS = 32;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   // host controller register map, byte offsets on ahb
   localparam logic [7:0] HC_CTRL = 8'h00;
   localparam logic [7:0] HC_STAT = 8'h04;
   localparam logic [7:0] HC_IRQ_STAT = 8'h08;
   localparam logic [7:0] HC_IRQ_CLR = 8'h0c;
   localparam logic [7:0] HC_IRQ_EN = 8'h10;
   localparam logic [2:0] HC_MSG_PAGE = 3'h1;
   localparam int IRQ_OK = 0;
   localparam int IRQ_FAULT = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- verilog/pdt_link_if.sv
// register link and line pins between host controller and device
`timescale 1ns/1ps
interface pdt_link_if;
   logic txn;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic alert_n;
   logic cc_out;
   logic cc_oe;
   modport dev (input txn, input wr, input rd, input addr, input wdata,
                output rdata, output alert_n, output cc_out, output cc_oe);
   modport host (output txn, output wr, output rd, output addr, output wdata,
                 input rdata, input alert_n);
endinterface

//--- verilog/pdt_device.sv
// device end: transmit buffer, alert status and bmc line sender
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module pdt_device (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link to the host
   pdt_link_if.dev lnk,
   // user side
   output logic tx_busy,
   output logic tx_done
);
   typedef enum logic [2:0] {
      PDT_IDLE = 3'b000,
      PDT_PRE = 3'b001,
      PDT_DATA = 3'b011,
      PDT_CRC = 3'b010
   } pdt_tx_state_t;

   pdt_tx_state_t state_r;
   logic [7:0] buf_r [0:pdt_pkg::TX_BUF_LEN-1];
   logic [7:0] st_lo_r;
   logic [7:0] st_hi_r;
   logic [7:0] mask_lo_r;
   logic [7:0] mask_hi_r;
   logic [7:0] cmd_r;
   logic [7:0] rdata_r;
   logic txn_d_r;
   logic touched_r;
   logic [1:0] loads_r;
   logic [4:0] hc_r;
   logic ph_r;
   logic lvl_r;
   logic [2:0] bitc_r;
   logic [4:0] byte_r;
   logic [6:0] cnt_r;
   logic [31:0] crc_r;

   // link decode
   wire in_buf = lnk.addr >= pdt_pkg::ADDR_TX_BUF && lnk.addr <= pdt_pkg::ADDR_TX_BUF_END;
   wire [4:0] buf_idx = 5'(lnk.addr - pdt_pkg::ADDR_TX_BUF);
   wire idle = state_r == PDT_IDLE;
   // buffer frozen while sending so the frame stays consistent
   wire wr_buf = lnk.wr && in_buf && idle;
   wire wr_cmd = lnk.wr && lnk.addr == pdt_pkg::ADDR_TX_CMD;
   wire wr_clo = lnk.wr && lnk.addr == pdt_pkg::ADDR_ALERT_LO;
   wire wr_chi = lnk.wr && lnk.addr == pdt_pkg::ADDR_ALERT_HI;
   wire wr_mlo = lnk.wr && lnk.addr == pdt_pkg::ADDR_MASK_LO;
   wire wr_mhi = lnk.wr && lnk.addr == pdt_pkg::ADDR_MASK_HI;
   wire send_req = wr_cmd && lnk.wdata == pdt_pkg::CMD_SEND;
   wire cmd_ok = send_req && idle && loads_r == 2'd1;
   wire cmd_bad = send_req && !cmd_ok;
   wire txn_end = txn_d_r && !lnk.txn;
   wire txn_start = !txn_d_r && lnk.txn;

   // frame sizing; an oversize count is clamped to what the buffer holds
   wire [7:0] cnt_raw = buf_r[0];
   wire [4:0] data_cnt = (cnt_raw > pdt_pkg::MAX_DATA_BYTES) ?
                         5'(pdt_pkg::MAX_DATA_BYTES) : cnt_raw[4:0];
   wire tick = hc_r == 5'(pdt_pkg::HALF_UI_CYC - 1);
   wire bit_end = tick && ph_r;
   wire [7:0] cur_byte = buf_r[byte_r];
   wire data_bit = cur_byte[bitc_r];
   wire cur_bit = (state_r == PDT_PRE) ? cnt_r[0] :
                  (state_r == PDT_DATA) ? data_bit : crc_r[0];
   wire [31:0] crc_upd = {1'b0, crc_r[31:1]} ^
                         ((crc_r[0] ^ cur_bit) ? pdt_pkg::CRC_POLY : 32'h00000000);
   wire pre_last = cnt_r == 7'(pdt_pkg::PREAMBLE_BITS - 1);
   wire crc_last = cnt_r == 7'(pdt_pkg::CRC_BITS - 1);
   wire byte_last = bitc_r == 3'h7 && byte_r == data_cnt;
   wire tx_fin = state_r == PDT_CRC && bit_end && crc_last;

   wire [7:0] set_lo = tx_fin ? pdt_pkg::ST_SEND_OK : pdt_pkg::BYTE_ZERO;
   wire [7:0] set_hi = cmd_bad ? pdt_pkg::ST_FAULT : pdt_pkg::BYTE_ZERO;
   wire [7:0] clr_lo = wr_clo ? lnk.wdata : pdt_pkg::BYTE_ZERO;
   wire [7:0] clr_hi = wr_chi ? lnk.wdata : pdt_pkg::BYTE_ZERO;

   wire [7:0] rd_val = (lnk.addr == pdt_pkg::ADDR_ALERT_LO) ? st_lo_r :
                       (lnk.addr == pdt_pkg::ADDR_ALERT_HI) ? st_hi_r :
                       (lnk.addr == pdt_pkg::ADDR_MASK_LO) ? mask_lo_r :
                       (lnk.addr == pdt_pkg::ADDR_MASK_HI) ? mask_hi_r :
                       (lnk.addr == pdt_pkg::ADDR_TX_CMD) ? cmd_r : pdt_pkg::BYTE_ZERO;

   always_ff @(posedge hclk) begin
      if (wr_buf) begin
         buf_r[buf_idx] <= lnk.wdata;
      end
   end

   // status, masks and readback; a set in the clearing cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_lo_r <= pdt_pkg::BYTE_ZERO;
         st_hi_r <= pdt_pkg::BYTE_ZERO;
         mask_lo_r <= pdt_pkg::MASK_RST;
         mask_hi_r <= pdt_pkg::MASK_RST;
         cmd_r <= pdt_pkg::BYTE_ZERO;
         rdata_r <= pdt_pkg::BYTE_ZERO;
      end else begin
         st_lo_r <= (st_lo_r & ~clr_lo) | set_lo;
         st_hi_r <= (st_hi_r & ~clr_hi) | set_hi;
         if (wr_mlo) begin
            mask_lo_r <= lnk.wdata;
         end
         if (wr_mhi) begin
            mask_hi_r <= lnk.wdata;
         end
         if (wr_cmd) begin
            cmd_r <= lnk.wdata;
         end
         if (lnk.rd) begin
            rdata_r <= rd_val;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txn_d_r <= 1'b0;
         touched_r <= 1'b0;
         loads_r <= 2'd0;
      end else begin
         txn_d_r <= lnk.txn;
         // a write in the opening cycle belongs to the new txn
         if (txn_start) begin
            touched_r <= wr_buf;
         end else if (wr_buf) begin
            touched_r <= 1'b1;
         end
         if (send_req) begin
            loads_r <= 2'd0;
         end else if (txn_end && touched_r && loads_r != 2'd2) begin
            loads_r <= loads_r + 2'd1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= PDT_IDLE;
         hc_r <= 5'h00;
         ph_r <= 1'b0;
         lvl_r <= 1'b0;
         bitc_r <= 3'h0;
         byte_r <= 5'h01;
         cnt_r <= 7'h00;
         crc_r <= pdt_pkg::CRC_INIT;
      end else if (idle) begin
         hc_r <= 5'h00;
         ph_r <= 1'b0;
         bitc_r <= 3'h0;
         byte_r <= 5'h01;
         cnt_r <= 7'h00;
         crc_r <= pdt_pkg::CRC_INIT;
         if (cmd_ok) begin
            state_r <= PDT_PRE;
            lvl_r <= ~lvl_r;
         end
      end else begin
         hc_r <= tick ? 5'h00 : hc_r + 5'h01;
         if (tick && !ph_r) begin
            ph_r <= 1'b1;
            // a one toggles mid-bit as well
            if (cur_bit) begin
               lvl_r <= ~lvl_r;
            end
         end
         if (bit_end) begin
            ph_r <= 1'b0;
            lvl_r <= ~lvl_r;
            cnt_r <= cnt_r + 7'h01;
            case (state_r)
               PDT_PRE: begin
                  if (pre_last) begin
                     cnt_r <= 7'h00;
                     if (data_cnt == 5'h00) begin
                        state_r <= PDT_CRC;
                        crc_r <= ~crc_r;
                     end else begin
                        state_r <= PDT_DATA;
                     end
                  end
               end
               PDT_DATA: begin
                  bitc_r <= bitc_r + 3'h1;
                  cnt_r <= 7'h00;
                  if (bitc_r == 3'h7) begin
                     byte_r <= byte_r + 5'h01;
                  end
                  crc_r <= byte_last ? ~crc_upd : crc_upd;
                  if (byte_last) begin
                     state_r <= PDT_CRC;
                  end
               end
               PDT_CRC: begin
                  crc_r <= {1'b0, crc_r[31:1]};
                  if (crc_last) begin
                     state_r <= PDT_IDLE;
                     lvl_r <= 1'b0;
                  end
               end
               default: begin
                  state_r <= PDT_IDLE;
               end
            endcase
         end
      end
   end

   assign lnk.rdata = rdata_r;
   assign lnk.alert_n = ~|((st_lo_r & mask_lo_r) | (st_hi_r & mask_hi_r));
   assign lnk.cc_out = lvl_r;
   assign lnk.cc_oe = !idle;
   assign tx_busy = !idle;
   assign tx_done = tx_fin;
endmodule

//--- verilog/pdt_host.sv
// host end: ahb-lite controller that loads, sends and clears a message
`timescale 1ns/1ps
module pdt_host (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // interrupt
   output logic irq,
   // link to the device
   pdt_link_if.host lnk
);
   typedef enum logic [3:0] {
      HS_IDLE = 4'b0000,
      HS_WRB = 4'b0001,
      HS_GAP = 4'b0011,
      HS_CMD = 4'b0010,
      HS_WAITA = 4'b0110,
      HS_RD0 = 4'b0111,
      HS_RD1 = 4'b0101,
      HS_RDX = 4'b0100,
      HS_GAP2 = 4'b1100,
      HS_CLR0 = 4'b1101,
      HS_CLR1 = 4'b1111,
      HS_FIN = 4'b1110
   } pdt_host_state_t;

   pdt_host_state_t state_r;
   logic [31:0] msg_r [0:7];
   logic [1:0] irq_st_r;
   logic [1:0] irq_en_r;
   logic [7:0] alo_r;
   logic [7:0] ahi_r;
   logic [4:0] bi_r;
   logic a_wr_r;
   logic [7:0] a_addr_r;
   logic [31:0] hrdata_r;

   // ahb decode; size is ignored, only whole words are expected
   wire a_take = hsel && hready && htrans == pdt_pkg::HTRANS_NONSEQ;
   wire w_ctrl = a_wr_r && a_addr_r == pdt_pkg::HC_CTRL && hwdata[0];
   wire w_clr = a_wr_r && a_addr_r == pdt_pkg::HC_IRQ_CLR;
   wire w_en = a_wr_r && a_addr_r == pdt_pkg::HC_IRQ_EN;
   wire w_msg = a_wr_r && a_addr_r[7:5] == pdt_pkg::HC_MSG_PAGE;
   wire [7:0] r_addr = haddr[7:0];
   wire [31:0] r_stat = {8'h00, ahi_r, alo_r, 7'h00, state_r != HS_IDLE};
   wire [31:0] r_val = (r_addr == pdt_pkg::HC_STAT) ? r_stat :
                       (r_addr == pdt_pkg::HC_IRQ_STAT) ? {30'h0, irq_st_r} :
                       (r_addr == pdt_pkg::HC_IRQ_EN) ? {30'h0, irq_en_r} :
                       (r_addr[7:5] == pdt_pkg::HC_MSG_PAGE) ? msg_r[r_addr[4:2]] :
                       32'h00000000;

   // message bytes, byte 0 is the count
   // little-endian byte order
   wire [31:0] cur_word = msg_r[bi_r[4:2]];
   wire [7:0] cur_byte = cur_word[{bi_r[1:0], 3'h0} +: 8];
   wire [7:0] cnt_byte = msg_r[0][7:0];
   wire [4:0] last_idx = (cnt_byte > pdt_pkg::MAX_DATA_BYTES) ?
                         5'(pdt_pkg::MAX_DATA_BYTES) : cnt_byte[4:0];
   wire done_ok = state_r == HS_FIN && (alo_r & pdt_pkg::ST_SEND_OK) != 8'h00;
   wire done_bad = state_r == HS_FIN && (ahi_r & pdt_pkg::ST_FAULT) != 8'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_wr_r <= 1'b0;
         a_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
      end else begin
         a_wr_r <= a_take && hwrite;
         a_addr_r <= haddr[7:0];
         if (a_take && !hwrite) begin
            hrdata_r <= r_val;
         end
      end
   end

   always_ff @(posedge hclk) begin
      if (w_msg) begin
         msg_r[a_addr_r[4:2]] <= hwdata;
      end
   end

   // irq status: a new event beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_r <= 2'b00;
         irq_en_r <= 2'b00;
      end else begin
         irq_st_r <= (irq_st_r & ~(w_clr ? hwdata[1:0] : 2'b00)) | {done_bad, done_ok};
         if (w_en) begin
            irq_en_r <= hwdata[1:0];
         end
      end
   end

   // transfer sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= HS_IDLE;
         bi_r <= 5'h00;
         alo_r <= 8'h00;
         ahi_r <= 8'h00;
      end else begin
         case (state_r)
            HS_IDLE: begin
               bi_r <= 5'h00;
               if (w_ctrl) begin
                  state_r <= HS_WRB;
               end
            end
            HS_WRB: begin
               bi_r <= bi_r + 5'h01;
               if (bi_r == last_idx) begin
                  state_r <= HS_GAP;
               end
            end
            HS_GAP: state_r <= HS_CMD;
            HS_CMD: state_r <= HS_WAITA;
            HS_WAITA: begin
               if (!lnk.alert_n) begin
                  state_r <= HS_RD0;
               end
            end
            HS_RD0: state_r <= HS_RD1;
            HS_RD1: begin
               alo_r <= lnk.rdata;
               state_r <= HS_RDX;
            end
            HS_RDX: begin
               ahi_r <= lnk.rdata;
               state_r <= HS_GAP2;
            end
            HS_GAP2: state_r <= HS_CLR0;
            HS_CLR0: state_r <= HS_CLR1;
            HS_CLR1: state_r <= HS_FIN;
            HS_FIN: state_r <= HS_IDLE;
            default: state_r <= HS_IDLE;
         endcase
      end
   end

   assign lnk.txn = state_r == HS_WRB || state_r == HS_CMD || state_r == HS_RD0 ||
                    state_r == HS_RD1 || state_r == HS_RDX || state_r == HS_CLR0 ||
                    state_r == HS_CLR1;
   assign lnk.wr = state_r == HS_WRB || state_r == HS_CMD || state_r == HS_CLR0 ||
                   state_r == HS_CLR1;
   assign lnk.rd = state_r == HS_RD0 || state_r == HS_RD1;
   assign lnk.addr = (state_r == HS_WRB) ? pdt_pkg::ADDR_TX_BUF + {3'h0, bi_r} :
                     (state_r == HS_CMD) ? pdt_pkg::ADDR_TX_CMD :
                     (state_r == HS_RD1 || state_r == HS_CLR1) ? pdt_pkg::ADDR_ALERT_HI :
                     pdt_pkg::ADDR_ALERT_LO;
   assign lnk.wdata = (state_r == HS_WRB) ? cur_byte :
                      (state_r == HS_CMD) ? pdt_pkg::CMD_SEND :
                      (state_r == HS_CLR1) ? ahi_r :
                      (state_r == HS_CLR0) ? alo_r : 8'h00;
   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(irq_st_r & irq_en_r);
endmodule

//--- verif/pdt_link_sva.sv
// concurrent checks on the device link of the transmit path
`timescale 1ns/1ps
module pdt_link_sva (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link signals
   input wire logic txn,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic alert_n,
   input wire logic cc_out,
   input wire logic cc_oe,
   // device user side
   input wire logic tx_busy,
   input wire logic tx_done
);
   localparam int H = pdt_pkg::HALF_UI_CYC;
   logic [7:0] run_r;
   logic last_r;
   wire cmd_w = wr && addr == pdt_pkg::ADDR_TX_CMD && wdata == pdt_pkg::CMD_SEND;
   wire edge_w = cc_out != last_r;
   wire zclr_w = wr && addr == pdt_pkg::ADDR_ALERT_LO && wdata == pdt_pkg::BYTE_ZERO;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // run length of the line level, saturating so idle never wraps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_r <= 8'h00;
         last_r <= 1'b0;
      end else begin
         last_r <= cc_out;
         if (edge_w) begin
            run_r <= 8'h00;
         end else if (run_r != 8'hff) begin
            run_r <= run_r + 8'h01;
         end
      end
   end
   property p_send_start; $rose(cc_oe) |-> $past(cmd_w); endproperty
   a_send_start: assert property (p_send_start)
      else $error("frame started without send command");
   property p_line_toggle; cc_oe && $past(cc_oe) && edge_w |-> run_r == H - 1 || run_r == 2 * H - 1;
   endproperty
   a_line_toggle: assert property (p_line_toggle)
      else $error("line transition off the unit grid");
   property p_frame_end; tx_done |=> !cc_oe && !cc_out; endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("line not released after last bit");
   property p_idle_line; !cc_oe |-> !cc_out; endproperty
   a_idle_line: assert property (p_idle_line)
      else $error("line level while not driven");
   property p_done_alert; tx_done |=> !alert_n; endproperty
   a_done_alert: assert property (p_done_alert)
      else $error("no alert after completion");
   property p_cmd_outcome; cmd_w && !tx_busy |=> cc_oe || !alert_n; endproperty
   a_cmd_outcome: assert property (p_cmd_outcome)
      else $error("send command neither sent nor flagged");
   property p_zero_clear; zclr_w && !alert_n |=> !alert_n; endproperty
   a_zero_clear: assert property (p_zero_clear)
      else $error("zero write cleared status");
   property p_rdata_hold; !rd |=> $stable(rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without read");
   c_frame: cover property (tx_done);
   c_cmd: cover property (cmd_w && !tx_busy);
   c_zclr: cover property (zclr_w);
endmodule

//--- verif/pd_message_transmit_path_tb.sv
// testbench: host and device joined, plus a rule-breaking link driver
`timescale 1ns/1ps
module pd_message_transmit_path_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic busy1;
   logic done1;
   logic busy2;
   logic done2;
   logic [31:0] q;
   logic [7:0] clr_lo = 8'h0;
   logic [7:0] clr_hi = 8'h0;
   logic [7:0] first_buf = 8'h0;
   int nbuf = 0;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [7:0] msg [20] = '{8'h12, 8'h61, 8'h43, 8'hf0, 8'h90, 8'h01, 8'h00, 8'h2c, 8'hd1,
      8'h02, 8'h00, 8'h2c, 8'hb1, 8'h04, 8'h00, 8'h2c, 8'h41, 8'h06, 8'h00, 8'h00};
   pdt_link_if lk ();
   pdt_link_if lk2 ();
   pdt_host pdt_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .lnk(lk.host));
   pdt_device pdt_device_i (.hclk(hclk), .hresetn(hresetn), .lnk(lk.dev), .tx_busy(busy1),
      .tx_done(done1));
   // second device faces the bench driver, which splits the load on purpose
   pdt_device pdt_device_i2 (.hclk(hclk), .hresetn(hresetn), .lnk(lk2.dev), .tx_busy(busy2),
      .tx_done(done2));
   pdt_link_sva pdt_link_sva_i (.hclk(hclk), .hresetn(hresetn), .txn(lk.txn), .wr(lk.wr),
      .rd(lk.rd), .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .alert_n(lk.alert_n),
      .cc_out(lk.cc_out), .cc_oe(lk.cc_oe), .tx_busy(busy1), .tx_done(done1));
   always #50 hclk = ~hclk;
   initial begin
      lk2.txn = 1'b0;
      lk2.wr = 1'b0;
      lk2.rd = 1'b0;
      lk2.addr = 8'h0;
      lk2.wdata = 8'h0;
   end
   always @(posedge hclk) begin
      cyc++;
      if (lk.wr === 1'b1) begin
         if (lk.addr === pdt_pkg::ADDR_ALERT_LO) clr_lo <= lk.wdata;
         if (lk.addr === pdt_pkg::ADDR_ALERT_HI) clr_hi <= lk.wdata;
         if (lk.addr === pdt_pkg::ADDR_TX_BUF) first_buf <= lk.wdata;
         if (lk.addr >= pdt_pkg::ADDR_TX_BUF && lk.addr <= pdt_pkg::ADDR_TX_BUF_END) nbuf++;
      end
      if (cyc == 40000) begin
         chk("timeout", 32'h0, 32'h1);
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one single transfer; waits on hready, no assumed latency
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= pdt_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic lk_op(input logic t, w, r, input logic [7:0] a, d);
      lk2.txn <= t;
      lk2.wr <= w;
      lk2.rd <= r;
      lk2.addr <= a;
      lk2.wdata <= d;
      @(posedge hclk);
   endtask
   task automatic t_send;
      logic bits[$];
      logic ex[$];
      logic [31:0] crc;
      logic a;
      logic fb;
      int i;
      for (i = 0; i < 5; i++) ahb(1'b1, 8'h20 + 8'(4 * i), {msg[4*i+3], msg[4*i+2],
         msg[4*i+1], msg[4*i]});
      ahb(1'b1, pdt_pkg::HC_IRQ_EN, 32'h3);
      ahb(1'b1, pdt_pkg::HC_CTRL, 32'h1);
      i = 0;
      while (lk.cc_oe !== 1'b1 && i < 500) begin
         @(posedge hclk);
         #1;
         i++;
      end
      // a one carries an extra mid-unit transition
      while (lk.cc_oe === 1'b1) begin
         repeat (8) @(posedge hclk);
         #1 a = lk.cc_out;
         repeat (16) @(posedge hclk);
         #1 bits.push_back(a ^ lk.cc_out);
         repeat (8) @(posedge hclk);
         #1;
      end
      @(posedge hclk);
      for (i = 0; i < pdt_pkg::PREAMBLE_BITS; i++) ex.push_back(i[0]);
      crc = pdt_pkg::CRC_INIT;
      for (i = 8; i < 8 * 19; i++) begin
         ex.push_back(msg[i/8][i%8]);
         fb = crc[0] ^ msg[i/8][i%8];
         crc = (crc >> 1) ^ (fb ? pdt_pkg::CRC_POLY : 32'h0);
      end
      for (i = 0; i < pdt_pkg::CRC_BITS; i++) ex.push_back(~crc[i]);
      chk("frame bit count", 32'(ex.size()), 32'(bits.size()));
      for (i = 0; i < ex.size(); i++) chk("frame bit", 32'(ex[i]),
         (i < bits.size()) ? 32'(bits[i]) : 32'hx);
      i = 0;
      while (irq !== 1'b1 && i < 3000) begin
         @(posedge hclk);
         i++;
      end
      ahb(1'b0, pdt_pkg::HC_IRQ_STAT, 32'h0);
      chk("irq status ok", 32'h1, q);
      ahb(1'b0, pdt_pkg::HC_STAT, 32'h0);
      chk("alert word and busy", 32'h00004000, q & 32'h00ffff01);
      chk("clear low byte", 32'h40, 32'(clr_lo));
      chk("clear high byte", 32'h0, 32'(clr_hi));
      chk("count byte", 32'h12, 32'(first_buf));
      chk("buffer writes", 32'd19, 32'(nbuf));
      chk("alert released", 32'h1, 32'(lk.alert_n));
      $display("test send done");
   endtask
   task automatic t_irq;
      chk("irq raised", 32'h1, 32'(irq));
      ahb(1'b1, pdt_pkg::HC_IRQ_EN, 32'h0);
      ahb(1'b0, pdt_pkg::HC_IRQ_EN, 32'h0);
      chk("irq enable", 32'h0, q);
      chk("irq masked", 32'h0, 32'(irq));
      ahb(1'b1, pdt_pkg::HC_IRQ_EN, 32'h3);
      ahb(1'b1, pdt_pkg::HC_IRQ_CLR, 32'h1);
      ahb(1'b0, pdt_pkg::HC_IRQ_STAT, 32'h0);
      chk("irq cleared", 32'h0, q);
      chk("irq low", 32'h0, 32'(irq));
      ahb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, q);
      chk("bus response", 32'h0, 32'(hresp));
      $display("test irq done");
   endtask
   task automatic t_split;
      lk_op(1'b1, 1'b1, 1'b0, pdt_pkg::ADDR_TX_BUF, 8'h02);
      lk_op(1'b1, 1'b1, 1'b0, 8'h52, 8'haa);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      lk_op(1'b1, 1'b1, 1'b0, 8'h53, 8'hbb);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      lk_op(1'b1, 1'b1, 1'b0, pdt_pkg::ADDR_TX_CMD, pdt_pkg::CMD_SEND);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      chk("split alert", 32'h0, 32'(lk2.alert_n));
      chk("split no frame", 32'h0, 32'(lk2.cc_oe));
      lk_op(1'b1, 1'b0, 1'b1, pdt_pkg::ADDR_ALERT_HI, 8'h0);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      chk("fault flag", 32'(pdt_pkg::ST_FAULT), 32'(lk2.rdata));
      lk_op(1'b1, 1'b0, 1'b1, pdt_pkg::ADDR_ALERT_LO, 8'h0);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      chk("no success flag", 32'h0, 32'(lk2.rdata));
      lk_op(1'b1, 1'b1, 1'b0, pdt_pkg::ADDR_ALERT_HI, pdt_pkg::BYTE_ZERO);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      chk("zero write kept", 32'h0, 32'(lk2.alert_n));
      lk_op(1'b1, 1'b1, 1'b0, pdt_pkg::ADDR_ALERT_HI, pdt_pkg::ST_FAULT);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      lk_op(1'b0, 1'b0, 1'b0, 8'h0, 8'h0);
      chk("fault cleared", 32'h1, 32'(lk2.alert_n));
      chk("split idle", 32'h0, 32'(busy2 | lk2.cc_oe));
      $display("test split done");
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_send();
      t_irq();
      t_split();
      results();
   end
endmodule
